// ==== shared/vcfr_cfg.svh ====
// constants for the valley count frequency reduction block
// How it works
// - judge feedback once per 48 ms period
// - always below low: step target up, max 7
// - between low and high: hold target
// - above high only: step target down, min 1
// - above reset threshold: load target with 1
// - target stays within 1 to 7
// - target starts at 1
// - line level picks low/high threshold set
// - valley count stays within 0 to 7
// - count falling crossings while switch off
// - clear valley count on gate rise
// - overvoltage while off latches after blanking
// - soft-start 12 ms in 4 steps
// - peak limit steps 0.32 V to 1 V
// - logic decides switch-on, analog decides switch-off
// - supply above turn-on: stop charging, soft-start
// - after suppression, on when count reaches target
// - off too long: force gate on
`ifndef VCFR_CFG_SVH
`define VCFR_CFG_SVH

// ********************************
// clock
// ********************************
`define VCFR_CLK_PERIOD_NS      20

// ********************************
// times in their own units
// ********************************
`define VCFR_UPDATE_PERIOD_MS   48
`define VCFR_SOFT_START_MS      12
`define VCFR_SOFT_START_STEPS   4
`define VCFR_MAX_OFF_NS         50000
`define VCFR_RS_SHORT_NS        2000
`define VCFR_RS_LONG_NS         25000
`define VCFR_OVP_BLANK_NS       1000

// ********************************
// derived cycle counts
// ********************************
`define VCFR_UPDATE_CYCLES ((`VCFR_UPDATE_PERIOD_MS * 1000000) / `VCFR_CLK_PERIOD_NS)
`define VCFR_SS_STEP_CYCLES \
	((`VCFR_SOFT_START_MS * 1000000) / (`VCFR_CLK_PERIOD_NS * `VCFR_SOFT_START_STEPS))
`define VCFR_MAX_OFF_CYCLES (`VCFR_MAX_OFF_NS / `VCFR_CLK_PERIOD_NS)
`define VCFR_RS_SHORT_CYCLES ((`VCFR_RS_SHORT_NS + `VCFR_CLK_PERIOD_NS - 1) / `VCFR_CLK_PERIOD_NS)
`define VCFR_RS_LONG_CYCLES ((`VCFR_RS_LONG_NS + `VCFR_CLK_PERIOD_NS - 1) / `VCFR_CLK_PERIOD_NS)
`define VCFR_OVP_BLANK_CYCLES \
	((`VCFR_OVP_BLANK_NS + `VCFR_CLK_PERIOD_NS - 1) / `VCFR_CLK_PERIOD_NS)

// ********************************
// counter limits and reset values
// ********************************
`define VCFR_TARGET_MIN         3'h1
`define VCFR_TARGET_MAX         3'h7
`define VCFR_TARGET_RESET       3'h1
`define VCFR_VALLEY_MAX         3'h7
`define VCFR_VALLEY_RESET       3'h0
`define VCFR_STEP_LAST          2'h3
`define VCFR_STEP_RESET         2'h0

// ********************************
// analog levels: ends of the peak limit step code, and the valley crossing level
// ********************************
`define VCFR_CS_LIMIT_START_MV  320
`define VCFR_CS_LIMIT_FINAL_MV  1000
`define VCFR_VALLEY_CROSS_MV    100

`endif

// ==== shared/vcfr_pkg.sv ====
// types shared by the valley count frequency reduction block
package vcfr_pkg;

	// ********************************
	// comparator inputs, one bit each
	// ********************************
	typedef struct packed {
		logic fb_above_low;     // feedback above fb_low_threshold
		logic fb_above_high;    // feedback above fb_high_threshold
		logic fb_above_reset;   // feedback above fb_reset_threshold
		logic valley_below;     // valley_sense below valley_crossing_threshold
		logic valley_above_ovp; // valley_sense above valley_overvoltage_threshold
		logic valley_above_rs;  // valley_sense above ringing suppression level
		logic supply_above_on;  // supply above supply_turn_on_threshold
		logic high_line;        // line level detector
		logic pwm_off;          // analog switch-off comparator
	} vcfr_analog_s;

	// ********************************
	// sticky feedback flags of a period
	// ********************************
	typedef struct packed {
		logic low;
		logic high;
		logic reset;
	} vcfr_fb_flags_s;

	typedef logic [2:0] vcfr_count_t;   // valley and target counters

	// operating phase, gray along charge -> run -> latched
	typedef enum logic [1:0] {
		VCFR_PH_CHARGE  = 2'b00,
		VCFR_PH_RUN     = 2'b01,
		VCFR_PH_LATCHED = 2'b11
	} vcfr_phase_e;

	// gate cycle, gray along on -> suppress -> wait
	typedef enum logic [1:0] {
		VCFR_GT_ON       = 2'b00,
		VCFR_GT_SUPPRESS = 2'b01,
		VCFR_GT_WAIT     = 2'b11
	} vcfr_gate_e;

endpackage

// ==== hw/vcfr_sync.sv ====
// two-flop synchroniser for a bundle of independent levels
module vcfr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;   // metastable stage, read only by stage two

	// ********************************
	// two stages, no logic between them
	// ********************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			stage1   <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// ==== hw/vcfr_valley_cnt.sv ====
// saturating valley counter, cleared when the gate turns on
`include "vcfr_cfg.svh"

module vcfr_valley_cnt (
	input  wire logic           clk,
	input  wire logic           resetn,
	input  wire logic           clear,
	input  wire logic           step,
	output vcfr_pkg::vcfr_count_t count
);

	// ********************************
	// count crossings, saturate at top
	// ********************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			count <= `VCFR_VALLEY_RESET;
		// clear wins: a crossing at turn-on belongs to the old cycle
		// clear on rise
		else if (clear)
			count <= `VCFR_VALLEY_RESET;
		else if (step)
		begin
			if (count != `VCFR_VALLEY_MAX)
				count <= count + 3'h1;
		end
	end

endmodule

// ==== hw/vcfr_top.sv ====
// switch-on control, valley counting, soft-start and latch-off
`include "vcfr_cfg.svh"

module vcfr_top #(
	parameter int UPDATE_CYCLES  = `VCFR_UPDATE_CYCLES,
	parameter int SS_STEP_CYCLES = `VCFR_SS_STEP_CYCLES,
	parameter int MAX_OFF_CYCLES = `VCFR_MAX_OFF_CYCLES,
	parameter int RS_SHORT_CYCLES = `VCFR_RS_SHORT_CYCLES,
	parameter int RS_LONG_CYCLES = `VCFR_RS_LONG_CYCLES,
	parameter int OVP_BLANK_CYCLES = `VCFR_OVP_BLANK_CYCLES
) (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire vcfr_pkg::vcfr_analog_s analog_in,
	output logic                        gate_output,
	output logic                        startup_cell_en,
	output logic                        fb_threshold_sel,
	output logic [1:0]                  cs_limit_step,
	output logic                        soft_start_active,
	output logic                        latched_off,
	output vcfr_pkg::vcfr_count_t       target_valley,
	output vcfr_pkg::vcfr_count_t       valley_count
);

	// ********************************
	// counter widths
	// ********************************
	localparam int UW = $clog2(UPDATE_CYCLES + 1);    // period counter
	localparam int SW = $clog2(SS_STEP_CYCLES + 1);   // soft-start step
	localparam int OW = $clog2(MAX_OFF_CYCLES + 1);   // off-time timer
	localparam int RW = $clog2(RS_LONG_CYCLES + RS_SHORT_CYCLES + 1);
	localparam int BW = $clog2(OVP_BLANK_CYCLES + 1); // ovp blanking

	localparam logic [UW-1:0] UPD_LAST = UW'(UPDATE_CYCLES - 1);
	localparam logic [SW-1:0] SS_LAST  = SW'(SS_STEP_CYCLES - 1);
	localparam logic [OW-1:0] OFF_LAST = OW'(MAX_OFF_CYCLES - 1);
	localparam logic [RW-1:0] RS_SHORT = RW'(RS_SHORT_CYCLES - 1);
	localparam logic [RW-1:0] RS_LONG  = RW'(RS_LONG_CYCLES - 1);
	localparam logic [BW-1:0] OVP_LAST = BW'(OVP_BLANK_CYCLES - 1);

	// ********************************
	// declarations
	// ********************************
	vcfr_pkg::vcfr_analog_s   cmp;             // synchronised comparators
	logic                     valley_below_d;  // last crossing level
	vcfr_pkg::vcfr_phase_e    phase;           // operating phase
	vcfr_pkg::vcfr_gate_e     gate_state;      // gate cycle state
	vcfr_pkg::vcfr_gate_e     next_gate_state; // its next value
	vcfr_pkg::vcfr_fb_flags_s sticky;          // flags of this period
	vcfr_pkg::vcfr_fb_flags_s seen;            // sticky or this cycle
	logic [UW-1:0]            upd_cnt;         // period position
	logic                     period_end;      // last cycle of a period
	logic [SW-1:0]            ss_cnt;          // position in a step
	logic [OW-1:0]            off_cnt;         // cycles with gate off
	logic [RW-1:0]            rs_cnt;          // suppression remaining
	logic [BW-1:0]            ovp_cnt;         // overvoltage persistence
	logic                     running;         // phase is run
	logic                     gate_rise;       // gate turns on this edge
	logic                     valley_step;     // one falling crossing

	// ********************************
	// target decision for a period
	// ********************************
	function automatic vcfr_pkg::vcfr_count_t next_target(
		input vcfr_pkg::vcfr_count_t    cur,
		input vcfr_pkg::vcfr_fb_flags_s f
	);
		vcfr_pkg::vcfr_count_t res;
		res = cur;
		if (f.reset)
			res = `VCFR_TARGET_MIN;
		else if (f.high)
		begin
			if (cur > `VCFR_TARGET_MIN)
				res = cur - 3'h1;
		end
		else if (f.low)
			res = cur;
		else
		begin
			if (cur < `VCFR_TARGET_MAX)
				res = cur + 3'h1;
		end
		return res;
	endfunction

	// ********************************
	// input synchronisers
	// ********************************
	// every comparator is analog, so all of them cross in
	vcfr_sync #(
		.WIDTH ($bits(vcfr_pkg::vcfr_analog_s))
	) u_sync (
		.clk      (clk),
		.resetn   (resetn),
		.async_in (analog_in),
		.sync_out (cmp)
	);

	// ********************************
	// valley counter
	// ********************************
	vcfr_valley_cnt u_valley (
		.clk    (clk),
		.resetn (resetn),
		.clear  (gate_rise),
		.step   (valley_step),
		.count  (valley_count)
	);

	assign running = (phase == vcfr_pkg::VCFR_PH_RUN);

	// falling ramp through the crossing level, switch off only
	// crossing while off
	assign valley_step = running && (gate_state != vcfr_pkg::VCFR_GT_ON)
		&& cmp.valley_below && !valley_below_d;

	// gate rising edge, seen one edge ahead of the output
	assign gate_rise = (next_gate_state == vcfr_pkg::VCFR_GT_ON)
		&& (gate_state != vcfr_pkg::VCFR_GT_ON);

	// ********************************
	// crossing edge history
	// ********************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			valley_below_d <= 1'b0;
		else
			valley_below_d <= cmp.valley_below;
	end

	// ********************************
	// start-up and latch-off phases
	// ********************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			phase <= vcfr_pkg::VCFR_PH_CHARGE;
		else
		begin
			unique case (phase)
				// waiting for the supply capacitor to charge
				vcfr_pkg::VCFR_PH_CHARGE:
				begin
					if (cmp.supply_above_on)
						phase <= vcfr_pkg::VCFR_PH_RUN;
				end
				// normal switching with soft-start first
				vcfr_pkg::VCFR_PH_RUN:
				begin
					if (cmp.valley_above_ovp && (ovp_cnt == OVP_LAST))
						phase <= vcfr_pkg::VCFR_PH_LATCHED;
				end
				// held until a fresh power-up reset
				vcfr_pkg::VCFR_PH_LATCHED:
					phase <= vcfr_pkg::VCFR_PH_LATCHED;
				default:
					phase <= vcfr_pkg::VCFR_PH_CHARGE;
			endcase
		end
	end

	// ********************************
	// start-up cell and latch flag
	// ********************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			startup_cell_en <= 1'b1;
			latched_off     <= 1'b0;
		end
		else
		begin
			startup_cell_en <= (phase == vcfr_pkg::VCFR_PH_CHARGE)
				&& !cmp.supply_above_on;
			latched_off <= (phase == vcfr_pkg::VCFR_PH_LATCHED)
				|| (running && cmp.valley_above_ovp && (ovp_cnt == OVP_LAST));
		end
	end

	// ********************************
	// overvoltage blanking
	// ********************************
	// a glitch shorter than the blanking restarts the count
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			ovp_cnt <= '0;
		else if (running && (gate_state != vcfr_pkg::VCFR_GT_ON)
			&& cmp.valley_above_ovp)
		begin
			if (ovp_cnt != OVP_LAST)
				ovp_cnt <= ovp_cnt + BW'(1);
		end
		else
			ovp_cnt <= '0;
	end

	// ********************************
	// soft-start stepping
	// ********************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ss_cnt            <= '0;
			cs_limit_step     <= `VCFR_STEP_RESET;
			soft_start_active <= 1'b0;
		end
		else if (!running)
		begin
			// restart from the lowest limit at every start-up
			ss_cnt            <= '0;
			cs_limit_step     <= `VCFR_STEP_RESET;
			soft_start_active <= (phase == vcfr_pkg::VCFR_PH_CHARGE)
				&& cmp.supply_above_on;
		end
		else if (soft_start_active)
		begin
			if (ss_cnt == SS_LAST)
			begin
				ss_cnt <= '0;
				if (cs_limit_step == `VCFR_STEP_LAST)
					soft_start_active <= 1'b0;
				else
					cs_limit_step <= cs_limit_step + 2'h1;
			end
			else
				ss_cnt <= ss_cnt + SW'(1);
		end
	end

	// ********************************
	// update period timer
	// ********************************
	assign period_end = running && (upd_cnt == UPD_LAST);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			upd_cnt <= '0;
		else if (!running || period_end)
			upd_cnt <= '0;
		else
			upd_cnt <= upd_cnt + UW'(1);
	end

	// ********************************
	// sticky feedback flags
	// ********************************
	assign seen.low   = sticky.low   || cmp.fb_above_low;
	assign seen.high  = sticky.high  || cmp.fb_above_high;
	assign seen.reset = sticky.reset || cmp.fb_above_reset;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			sticky <= '0;
		else if (!running)
			sticky <= '0;
		else if (period_end)
		begin
			sticky.low   <= cmp.fb_above_low;
			sticky.high  <= cmp.fb_above_high;
			sticky.reset <= cmp.fb_above_reset;
		end
		else
			sticky <= seen;
	end

	// ********************************
	// target valley counter
	// ********************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			target_valley <= `VCFR_TARGET_RESET;
		else if (phase == vcfr_pkg::VCFR_PH_CHARGE)
			target_valley <= `VCFR_TARGET_RESET;
		else if (period_end)
			target_valley <= next_target(target_valley, seen);
	end

	// ********************************
	// threshold set selection
	// ********************************
	// changed at the boundary so one period is judged on one set
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			fb_threshold_sel <= 1'b0;
		else if (!running || period_end)
			fb_threshold_sel <= cmp.high_line;
	end

	// ********************************
	// gate cycle decision
	// ********************************
	always_comb
	begin
		next_gate_state = gate_state;
		if (!running)
			next_gate_state = vcfr_pkg::VCFR_GT_WAIT;
		else
		begin
			unique case (gate_state)
				vcfr_pkg::VCFR_GT_ON:
				begin
					if (cmp.pwm_off)
						next_gate_state = vcfr_pkg::VCFR_GT_SUPPRESS;
				end
				vcfr_pkg::VCFR_GT_SUPPRESS:
				begin
					if (off_cnt == OFF_LAST)
						next_gate_state = vcfr_pkg::VCFR_GT_ON;
					else if (rs_cnt == '0)
						next_gate_state = vcfr_pkg::VCFR_GT_WAIT;
				end
				vcfr_pkg::VCFR_GT_WAIT:
				begin
					if (valley_count >= target_valley)
						next_gate_state = vcfr_pkg::VCFR_GT_ON;
					else if (off_cnt == OFF_LAST)
						next_gate_state = vcfr_pkg::VCFR_GT_ON;
				end
				default:
					next_gate_state = vcfr_pkg::VCFR_GT_WAIT;
			endcase
		end
	end

	// ********************************
	// gate state and output
	// ********************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gate_state  <= vcfr_pkg::VCFR_GT_WAIT;
			gate_output <= 1'b0;
		end
		else
		begin
			gate_state  <= next_gate_state;
			gate_output <= (next_gate_state == vcfr_pkg::VCFR_GT_ON);
		end
	end

	// ********************************
	// ringing suppression timer
	// ********************************
	// level at turn-off picks the length; low level rings longer
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rs_cnt <= '0;
		else if (next_gate_state == vcfr_pkg::VCFR_GT_SUPPRESS
			&& gate_state == vcfr_pkg::VCFR_GT_ON)
			rs_cnt <= cmp.valley_above_rs ? RS_SHORT : RS_LONG;
		else if (rs_cnt != '0)
			rs_cnt <= rs_cnt - RW'(1);
	end

	// ********************************
	// maximum off-time timer
	// ********************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			off_cnt <= '0;
		else if (!running || next_gate_state == vcfr_pkg::VCFR_GT_ON)
			off_cnt <= '0;
		else if (off_cnt != OFF_LAST)
			off_cnt <= off_cnt + OW'(1);
	end

endmodule

// ==== dv/vcfr_afe.sv ====
// analog front end model: comparators and switch-off stage facing the block
module vcfr_afe (
	input  wire logic              clk,
	input  wire logic              gate_output,
	input  wire logic [1:0]        fb_level,
	input  wire logic [2:0]        valleys,
	input  wire logic              ovp,
	input  wire logic              supply_on,
	input  wire logic              line_high,
	output vcfr_pkg::vcfr_analog_s analog_in
);
	timeunit 1ns;
	timeprecision 1ps;

	int on_cyc  = 0; // cycles since the gate rose
	int off_cyc = 0; // cycles since the gate fell

	// ****
	// gate timing seen by the winding
	// ****
	always @(posedge clk)
	begin
		on_cyc  <= gate_output ? on_cyc + 1 : 0;
		off_cyc <= gate_output ? 0 : off_cyc + 1;
	end

	// ****
	// comparator levels
	// ****
	// ringing gives one falling crossing per 8 cycles, then damps out below the level;
	// while the gate is on the pin is clamped low
	always_comb
	begin
		analog_in.fb_above_low     = fb_level >= 2'h1;
		analog_in.fb_above_high    = fb_level >= 2'h2;
		analog_in.fb_above_reset   = fb_level == 2'h3;
		analog_in.valley_below     = gate_output || off_cyc >= 8 * valleys || off_cyc[2];
		analog_in.valley_above_ovp = ovp && !gate_output;
		analog_in.valley_above_rs  = !gate_output && off_cyc < 4;
		analog_in.supply_above_on  = supply_on;
		analog_in.high_line        = line_high;
		analog_in.pwm_off          = gate_output && on_cyc >= 6;
	end
endmodule

// ==== dv/vcfr_chk.sv ====
// assertion checker for the valley count block, bound to its top
module vcfr_chk #(
	parameter int UPDATE_CYCLES  = 200,
	parameter int SS_STEP_CYCLES = 50,
	parameter int MAX_OFF_CYCLES = 300
) (
	input wire logic                  clk,
	input wire logic                  resetn,
	input wire logic                  gate_output,
	input wire logic                  startup_cell_en,
	input wire logic [1:0]            cs_limit_step,
	input wire logic                  soft_start_active,
	input wire logic                  latched_off,
	input wire vcfr_pkg::vcfr_count_t target_valley,
	input wire vcfr_pkg::vcfr_count_t valley_count
);
	timeunit 1ns;
	timeprecision 1ps;

	int                    gap;     // cycles since the target last moved
	int                    ss_cnt;  // cycles spent in soft-start
	int                    off_cnt; // cycles with the gate off, latch excluded
	vcfr_pkg::vcfr_count_t tgt_q;   // target one cycle ago

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// ****
	// helper counters
	// ****
	// off_cnt also runs in charge, so it may overestimate by a few cycles
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gap     <= 0;
			ss_cnt  <= 0;
			off_cnt <= 0;
			tgt_q   <= 3'h1;
		end
		else
		begin
			tgt_q   <= target_valley;
			gap     <= (target_valley != tgt_q) ? 0 : gap + 1;
			ss_cnt  <= soft_start_active ? ss_cnt + 1 : ss_cnt;
			off_cnt <= (gate_output || latched_off) ? 0 : off_cnt + 1;
		end
	end

	// ****
	// properties
	// ****
	target_range_a: assert property (target_valley != 3'h0)
		else $error("target left its range");
	target_gap_a: assert property (target_valley != tgt_q |-> gap >= UPDATE_CYCLES - 2)
		else $error("target moved between periods");
	charge_idle_a: assert property (startup_cell_en |-> target_valley == 3'h1 && !gate_output)
		else $error("charge phase not idle");
	cell_once_a: assert property (!startup_cell_en |=> !startup_cell_en)
		else $error("charging cell came back");
	start_soft_a: assert property ($fell(startup_cell_en)
			|-> soft_start_active && cs_limit_step == 2'h0)
		else $error("start without soft-start");
	// a latch-off drops the code back to the lowest step
	step_up_a: assert property ($changed(cs_limit_step)
			|-> (latched_off && cs_limit_step == 2'h0)
			|| ($past(soft_start_active) && cs_limit_step == $past(cs_limit_step) + 2'h1))
		else $error("limit step jumped");
	ss_length_a: assert property ($fell(soft_start_active)
			|-> cs_limit_step == 2'h3 && ss_cnt >= 4 * SS_STEP_CYCLES - 2
			&& ss_cnt <= 4 * SS_STEP_CYCLES + 2)
		else $error("soft-start length wrong");
	valley_clear_a: assert property ($rose(gate_output) |-> valley_count == 3'h0)
		else $error("valley count not cleared");
	valley_step_a: assert property ($changed(valley_count) && valley_count != 3'h0
			|-> valley_count == $past(valley_count) + 3'h1)
		else $error("valley count skipped");
	on_count_a: assert property (gate_output |=> $stable(valley_count))
		else $error("valley counted while on");
	turn_on_a: assert property ($rose(gate_output)
			|-> $past(valley_count) >= $past(target_valley)
			|| $past(off_cnt) >= MAX_OFF_CYCLES - 3)
		else $error("gate on too early");
	max_off_a: assert property (off_cnt <= MAX_OFF_CYCLES + 6)
		else $error("gate off too long");
	latch_hold_a: assert property (latched_off |=> latched_off && !gate_output)
		else $error("latch released");
endmodule

bind vcfr_top vcfr_chk #(
	.UPDATE_CYCLES  (UPDATE_CYCLES),
	.SS_STEP_CYCLES (SS_STEP_CYCLES),
	.MAX_OFF_CYCLES (MAX_OFF_CYCLES)
) u_chk (
	.clk,
	.resetn,
	.gate_output,
	.startup_cell_en,
	.cs_limit_step,
	.soft_start_active,
	.latched_off,
	.target_valley,
	.valley_count
);

// ==== dv/tb.sv ====
// self-checking bench for the valley count frequency reduction block
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int UPD = 1000; // shortened update period
	localparam int SSS = 50;   // shortened soft-start step
	localparam int MOF = 300;  // shortened max off time
	localparam int RSL = 20;   // shortened long ringing suppression

	logic                   clk;
	logic                   resetn;
	logic [1:0]             fb_level;    // 0 below low .. 3 above reset
	logic [2:0]             valleys;     // ringing crossings per off time
	logic                   ovp;
	logic                   supply_on;
	logic                   line_high;
	vcfr_pkg::vcfr_analog_s analog_in;
	logic                   gate_output;
	logic                   startup_cell_en;
	logic                   fb_threshold_sel;
	logic [1:0]             cs_limit_step;
	logic                   soft_start_active;
	logic                   latched_off;
	vcfr_pkg::vcfr_count_t  target_valley;
	vcfr_pkg::vcfr_count_t  valley_count;
	int                     errors;
	int                     compares;

	vcfr_top #(
		.UPDATE_CYCLES    (UPD),
		.SS_STEP_CYCLES   (SSS),
		.MAX_OFF_CYCLES   (MOF),
		.RS_SHORT_CYCLES  (5),
		.RS_LONG_CYCLES   (RSL),
		.OVP_BLANK_CYCLES (4)
	) DUT (
		.clk               (clk),
		.resetn            (resetn),
		.analog_in         (analog_in),
		.gate_output       (gate_output),
		.startup_cell_en   (startup_cell_en),
		.fb_threshold_sel  (fb_threshold_sel),
		.cs_limit_step     (cs_limit_step),
		.soft_start_active (soft_start_active),
		.latched_off       (latched_off),
		.target_valley     (target_valley),
		.valley_count      (valley_count)
	);

	vcfr_afe u_afe (
		.clk         (clk),
		.gate_output (gate_output),
		.fb_level    (fb_level),
		.valleys     (valleys),
		.ovp         (ovp),
		.supply_on   (supply_on),
		.line_high   (line_high),
		.analog_in   (analog_in)
	);

	// ****
	// helpers
	// ****
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic test_done();
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask

	// inputs always move 2 ns after an edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic wait_until(ref logic sig, input logic val, input int lim);
		int n = 0;
		while (sig !== val && n < lim)
		begin
			tick(1);
			n++;
		end
		if (sig !== val)
		begin
			errors++;
			$display("MISMATCH %0t wait timed out", $time);
			test_done();
		end
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset();
		check(8'(target_valley), 8'h1, "target at reset");
		check(8'(valley_count), 8'h0, "valley count at reset");
		check(8'(startup_cell_en), 8'h1, "cell at reset");
		check(8'(gate_output), 8'h0, "gate at reset");
		check(8'(latched_off), 8'h0, "latch at reset");
	endtask

	task automatic t_startup();
		int n;
		supply_on = 1'b1;
		wait_until(startup_cell_en, 1'b0, 10);
		check(8'(soft_start_active), 8'h1, "soft-start begins");
		check(8'(cs_limit_step), 8'h0, "first limit step");
		for (int k = 1; k < 5; k++)
		begin
			n = 0;
			while ((k < 4 ? cs_limit_step !== 2'(k) : soft_start_active !== 1'b0) && n < 2 * SSS)
			begin
				tick(1);
				n++;
			end
			if (k > 1)
				check(8'(n), 8'(SSS), "soft-start step length");
		end
		check(8'(cs_limit_step), 8'h3, "final limit step");
	endtask

	// leaves the bench 3 cycles after a boundary
	task automatic wait_target(input logic [2:0] exp, input int lim);
		int n = 0;
		while (target_valley !== exp && n < lim)
		begin
			tick(1);
			n++;
		end
		check(8'(target_valley), 8'(exp), "target step");
		if (target_valley !== exp)
			test_done();
		tick(3);
	endtask

	// feedback a for 4 cycles mid-period, then b; judged 3 cycles after the boundary
	task automatic period(input logic [1:0] a, input logic [1:0] b, input logic [2:0] exp);
		tick(UPD / 2 - 3);
		fb_level = a;
		tick(4);
		fb_level = b;
		tick(UPD / 2 - 1);
		check(8'(target_valley), 8'(exp), "target after period");
	endtask

	task automatic gate_check(input logic [2:0] nv, input logic by_count);
		int         n = 0;
		logic [2:0] last;
		wait_until(gate_output, 1'b1, 2 * MOF);
		valleys = nv;
		wait_until(gate_output, 1'b0, 50);
		while (gate_output !== 1'b1 && n < 2 * MOF)
		begin
			last = valley_count;
			tick(1);
			n++;
		end
		if (by_count)
			// turn-off level is low here, so the long suppression must pass first
			check(8'(last >= target_valley && n >= RSL && n < MOF - 1), 8'h1, "on at target");
		else
		begin
			check(8'(last), 8'(nv), "valleys counted");
			check(8'(n >= MOF - 1 && n <= MOF + 1), 8'h1, "max off time");
		end
		check(8'(valley_count), 8'h0, "count cleared at turn-on");
	endtask

	// short overvoltage is blanked, a long one latches for good
	task automatic t_ovp();
		valleys = 3'h0;
		wait_until(gate_output, 1'b1, 2 * MOF);
		wait_until(gate_output, 1'b0, 50);
		tick(20);
		ovp = 1'b1;
		tick(2);
		ovp = 1'b0;
		tick(20);
		check(8'(latched_off), 8'h0, "short overvoltage blanked");
		ovp = 1'b1;
		tick(10);
		check(8'(latched_off), 8'h1, "overvoltage latch");
		ovp = 1'b0;
		tick(2 * MOF);
		check(8'(gate_output), 8'h0, "gate held off");
	endtask

	// ****
	// main sequence
	// ****
	initial
	begin
		resetn = 1'b0;
		fb_level = 2'h0;
		valleys = 3'h7;
		ovp = 1'b0;
		supply_on = 1'b0;
		line_high = 1'b0;
		errors = 0;
		compares = 0;
		tick(6);
		t_reset();
		resetn = 1'b1;
		t_startup();
		wait_target(3'h2, 2 * UPD);
		for (int k = 3; k < 8; k++)
			period(2'h0, 2'h0, 3'(k));
		period(2'h0, 2'h0, 3'h7);
		gate_check(3'h7, 1'b1);
		gate_check(3'h4, 1'b0);
		fb_level = 2'h2;
		wait_target(3'h6, 2 * UPD);
		line_high = 1'b1;
		period(2'h1, 2'h1, 3'h5);
		check(8'(fb_threshold_sel), 8'h1, "threshold set follows line");
		period(2'h1, 2'h1, 3'h5);
		period(2'h2, 2'h1, 3'h4);
		period(2'h1, 2'h1, 3'h4);
		period(2'h3, 2'h0, 3'h1);
		period(2'h0, 2'h0, 3'h2);
		period(2'h2, 2'h2, 3'h1);
		period(2'h2, 2'h2, 3'h1);
		gate_check(3'h3, 1'b1);
		t_ovp();
		resetn = 1'b0;
		tick(1);
		t_reset();
		test_done();
	end
endmodule
